// ==== hw/dma_handshake.sv ====
// Top of the message-buffer DMA handshake: APB registers, receive read
// channel and transmit write channel toward an external DMA controller.
// Assumes all pins and the user-side buffer ports are synchronous to CLK_SYS.
`timescale 1ns/1ps

// Overview of operation
// - A 0-to-1 change of the transmit soft reset bit resets the transmit write channel.
// - With the write-pin role bit at 0, the write pin is direction and read pin strobes.
// - With the write-pin role bit at 1, the write pin is the write strobe.
// - A three-bit field selects the framer channel using the transmit interface.
// - A 0-to-1 change of the receive soft reset bit resets the receive read channel.
// - The receive enable bit turns the read interface on; at 0 the channel drops to idle on the next clock and reads stop.
// - The receive request is raised only when a whole message sits in the buffer.
// - The receive channel moves message bytes out toward external memory.
// - A receive cycle starts by pulling the receive request line low.
// - With the read pin as a read strobe, each low read pulse presents a new byte.
// - With the read pin as direction, each low write pulse presents a new byte.
// - With the read-pin role bit at 0, the read pin is a read strobe.
// - With the read-pin role bit at 1, read is direction and write is the strobe.
module dma_handshake (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic [31:0]      PRDATA,
  // DMA pins
  input  wire logic        RD_N,
  input  wire logic        WR_N,
  input  wire logic [7:0]  DATA_IN,
  output logic [7:0]       DATA_OUT,
  output logic             DATA_OE,
  output logic             RX_DMA_REQUEST_N,
  input  wire logic        RX_DMA_ACKNOWLEDGE_N,
  output logic             TX_DMA_REQUEST_N,
  input  wire logic        TX_DMA_ACKNOWLEDGE_N,
  // Framer receive side: bytes in, end-of-message marker
  input  wire logic        RX_BYTE_VALID,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        RX_BYTE_LAST,
  output logic             RX_BYTE_READY,
  // Framer transmit side: bytes out, space indication
  input  wire logic        TX_SPACE,
  output logic             TX_BYTE_VALID,
  output logic [7:0]       TX_BYTE,
  output logic [2:0]       TX_CHANNEL,
  output logic [2:0]       RX_CHANNEL
);

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic [7:0] tx_dma_write_config_q;
  logic [7:0] rx_dma_read_config_q;
  wire        apb_wr;
  wire        apb_rd;
  wire        sel_tx;
  wire        sel_rx;
  wire        sel_st;
  wire        sel_fill;
  wire        mapped;

  // Zero-wait slave: every access completes in its first access cycle
  assign sel_tx   = PADDR == dma_hs_pkg::TX_DMA_WRITE_CONFIG_ADDR;
  assign sel_rx   = PADDR == dma_hs_pkg::RX_DMA_READ_CONFIG_ADDR;
  assign sel_st   = PADDR == dma_hs_pkg::DMA_STATUS_ADDR;
  assign sel_fill = PADDR == dma_hs_pkg::RX_FILL_ADDR;
  assign mapped   = sel_tx | sel_rx | sel_st | sel_fill;
  assign apb_wr   = PSEL & PENABLE & PWRITE;
  assign apb_rd   = PSEL & PENABLE & ~PWRITE;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL & PENABLE & ~mapped;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  wire [7:0] wdata_masked;
  assign wdata_masked = PWDATA[7:0] & dma_hs_pkg::CONFIG_WMASK;

  // Reserved bits 4:3 are never stored, so they read back zero
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_dma_write_config_q <= dma_hs_pkg::CONFIG_RESET;
      rx_dma_read_config_q  <= dma_hs_pkg::CONFIG_RESET;
    end
    else
    begin
      if (apb_wr && sel_tx)
        tx_dma_write_config_q <= wdata_masked;
      if (apb_wr && sel_rx)
        rx_dma_read_config_q <= wdata_masked;
    end
  end

  wire tx_soft_reset;
  wire rx_soft_reset;
  wire tx_dma_enable_bit;
  wire rx_dma_enable_bit;
  wire wr_role;
  wire rd_role;
  assign tx_soft_reset     = tx_dma_write_config_q[dma_hs_pkg::SOFT_RESET_BIT];
  assign rx_soft_reset     = rx_dma_read_config_q[dma_hs_pkg::SOFT_RESET_BIT];
  assign tx_dma_enable_bit = tx_dma_write_config_q[dma_hs_pkg::ENABLE_BIT];
  assign rx_dma_enable_bit = rx_dma_read_config_q[dma_hs_pkg::ENABLE_BIT];
  assign wr_role           = tx_dma_write_config_q[dma_hs_pkg::PIN_ROLE_BIT];
  assign rd_role           = rx_dma_read_config_q[dma_hs_pkg::PIN_ROLE_BIT];

  // ****************************************************************
  // Soft reset edge detect
  // ****************************************************************
  logic tx_rst_prev_q;
  logic rx_rst_prev_q;
  wire  tx_chan_reset;
  wire  rx_chan_reset;

  // Only the rising edge resets; holding the bit at 1 does nothing more
  assign tx_chan_reset = tx_soft_reset & ~tx_rst_prev_q;
  assign rx_chan_reset = rx_soft_reset & ~rx_rst_prev_q;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_rst_prev_q <= 1'b0;
      rx_rst_prev_q <= 1'b0;
    end
    else
    begin
      tx_rst_prev_q <= tx_soft_reset;
      rx_rst_prev_q <= rx_soft_reset;
    end
  end

  // ****************************************************************
  // Channel select outputs
  // ****************************************************************
  // Reserved top-bit codes fall back to channel 0; low codes 0 to 3 pass as written
  wire [2:0] tx_sel_raw;
  wire [2:0] rx_sel_raw;
  assign tx_sel_raw = tx_dma_write_config_q[dma_hs_pkg::CHAN_LSB +: dma_hs_pkg::CHAN_W];
  assign rx_sel_raw = rx_dma_read_config_q[dma_hs_pkg::CHAN_LSB +: dma_hs_pkg::CHAN_W];
  assign TX_CHANNEL = tx_sel_raw[2] ? dma_hs_pkg::CHAN_ZERO : tx_sel_raw;
  assign RX_CHANNEL = rx_sel_raw[2] ? dma_hs_pkg::CHAN_ZERO : rx_sel_raw;

  // ****************************************************************
  // Strobe decode
  // ****************************************************************
  dma_hs_pkg::strobe_pins_t pins;
  wire                      rx_strobe;
  wire                      tx_strobe;
  assign pins.rd_n = RD_N;
  assign pins.wr_n = WR_N;

  // Read role 0: read pin strobes; role 1: write pin strobes
  dma_strobe_edge u_rx_strobe (
    .clk                     (CLK_SYS),
    .rst_n                   (RST_N),
    .pins                    (pins),
    .role                    (rd_role),
    .role_is_direction_on_wr (1'b0),
    .strobe_fall             (rx_strobe)
  );

  // Write role 0: read pin strobes with write as direction; role 1: write strobes
  dma_strobe_edge u_tx_strobe (
    .clk                     (CLK_SYS),
    .rst_n                   (RST_N),
    .pins                    (pins),
    .role                    (wr_role),
    .role_is_direction_on_wr (1'b1),
    .strobe_fall             (tx_strobe)
  );

  // Direction qualifiers: in direction mode the other pin must say read/write
  wire rx_dir_ok;
  wire tx_dir_ok;
  assign rx_dir_ok = ~rd_role | RD_N;  // RD high means a read cycle
  assign tx_dir_ok = wr_role | ~WR_N;  // WR low means a write cycle

  // ****************************************************************
  // Receive message buffer
  // ****************************************************************
  logic [7:0]              rx_mem [dma_hs_pkg::BUF_DEPTH];
  logic [dma_hs_pkg::PTR_W:0] wr_ptr_q;
  logic [dma_hs_pkg::PTR_W:0] rd_ptr_q;
  logic [dma_hs_pkg::PTR_W:0] msg_end_q;
  logic                    msg_ready_q;
  wire                     buf_full;
  wire                     buf_push;
  wire                     buf_pop;
  wire [dma_hs_pkg::PTR_W:0] fill;

  assign fill          = wr_ptr_q - rd_ptr_q;
  assign buf_full      = fill[dma_hs_pkg::PTR_W];
  // Back-pressure to the framer: one message at a time is held
  assign RX_BYTE_READY = ~buf_full & ~msg_ready_q;
  assign buf_push      = RX_BYTE_VALID & RX_BYTE_READY;

  always_ff @(posedge CLK_SYS)
  begin
    if (buf_push)
      rx_mem[wr_ptr_q[dma_hs_pkg::PTR_W-1:0]] <= RX_BYTE;
  end

  // Complete-message flag; a soft reset discards the buffer
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_ptr_q    <= '0;
      msg_end_q   <= '0;
      msg_ready_q <= 1'b0;
    end
    else if (rx_chan_reset)
    begin
      wr_ptr_q    <= rd_ptr_q;
      msg_ready_q <= 1'b0;
    end
    else
    begin
      if (buf_push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (buf_push && RX_BYTE_LAST)
      begin
        msg_ready_q <= 1'b1;
        msg_end_q   <= wr_ptr_q + 1'b1;
      end
      else if (buf_pop && (rd_ptr_q + 1'b1 == msg_end_q))
        msg_ready_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Receive read channel
  // ****************************************************************
  dma_hs_pkg::ch_state_t rx_state_q;
  dma_hs_pkg::ch_state_t rx_state_d;
  logic [7:0]            data_out_q;

  // A strobe pops a byte while acknowledged and in the right direction
  assign buf_pop = (rx_state_q == dma_hs_pkg::CH_XFER) & rx_strobe & rx_dir_ok
                   & ~RX_DMA_ACKNOWLEDGE_N;

  always_comb
  begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      dma_hs_pkg::CH_IDLE:
        if (rx_dma_enable_bit && msg_ready_q)
          rx_state_d = dma_hs_pkg::CH_REQ;
      dma_hs_pkg::CH_REQ:
        if (!rx_dma_enable_bit)
          rx_state_d = dma_hs_pkg::CH_IDLE;
        else if (!RX_DMA_ACKNOWLEDGE_N)
          rx_state_d = dma_hs_pkg::CH_XFER;
      dma_hs_pkg::CH_XFER:
        if (!rx_dma_enable_bit || (buf_pop && (rd_ptr_q + 1'b1 == msg_end_q)))
          rx_state_d = dma_hs_pkg::CH_IDLE;
      default:
        rx_state_d = dma_hs_pkg::CH_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_state_q <= dma_hs_pkg::CH_IDLE;
      rd_ptr_q   <= '0;
      data_out_q <= 8'h00;
    end
    else if (rx_chan_reset)
    begin
      rx_state_q <= dma_hs_pkg::CH_IDLE;
      data_out_q <= 8'h00;
    end
    else
    begin
      rx_state_q <= rx_state_d;
      if (buf_pop)
      begin
        data_out_q <= rx_mem[rd_ptr_q[dma_hs_pkg::PTR_W-1:0]];
        rd_ptr_q   <= rd_ptr_q + 1'b1;
      end
    end
  end

  assign RX_DMA_REQUEST_N = ~((rx_state_q == dma_hs_pkg::CH_REQ) |
                              (rx_state_q == dma_hs_pkg::CH_XFER));
  assign DATA_OUT = data_out_q;
  // Drive the byte bus only while the controller acknowledges a read
  assign DATA_OE  = (rx_state_q == dma_hs_pkg::CH_XFER) & ~RX_DMA_ACKNOWLEDGE_N;

  // ****************************************************************
  // Transmit write channel
  // ****************************************************************
  dma_hs_pkg::ch_state_t tx_state_q;
  dma_hs_pkg::ch_state_t tx_state_d;
  logic                  tx_valid_q;
  logic [7:0]            tx_byte_q;
  wire                   tx_take;

  assign tx_take = (tx_state_q == dma_hs_pkg::CH_XFER) & tx_strobe & tx_dir_ok
                   & ~TX_DMA_ACKNOWLEDGE_N;

  always_comb
  begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      dma_hs_pkg::CH_IDLE:
        if (tx_dma_enable_bit && TX_SPACE)
          tx_state_d = dma_hs_pkg::CH_REQ;
      dma_hs_pkg::CH_REQ:
        if (!tx_dma_enable_bit)
          tx_state_d = dma_hs_pkg::CH_IDLE;
        else if (!TX_DMA_ACKNOWLEDGE_N)
          tx_state_d = dma_hs_pkg::CH_XFER;
      dma_hs_pkg::CH_XFER:
        if (!tx_dma_enable_bit || !TX_SPACE || TX_DMA_ACKNOWLEDGE_N)
          tx_state_d = dma_hs_pkg::CH_IDLE;
      default:
        tx_state_d = dma_hs_pkg::CH_IDLE;
    endcase
  end

  // Captured byte is offered to the framer for exactly one cycle
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_state_q <= dma_hs_pkg::CH_IDLE;
      tx_valid_q <= 1'b0;
      tx_byte_q  <= 8'h00;
    end
    else if (tx_chan_reset)
    begin
      tx_state_q <= dma_hs_pkg::CH_IDLE;
      tx_valid_q <= 1'b0;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      tx_valid_q <= tx_take;
      if (tx_take)
        tx_byte_q <= DATA_IN;
    end
  end

  assign TX_DMA_REQUEST_N = ~((tx_state_q == dma_hs_pkg::CH_REQ) |
                              (tx_state_q == dma_hs_pkg::CH_XFER));
  assign TX_BYTE_VALID    = tx_valid_q;
  assign TX_BYTE          = tx_byte_q;

  // ****************************************************************
  // APB read mux
  // ****************************************************************
  wire [31:0] status_word;
  assign status_word = {26'h0, msg_ready_q, buf_full,
                        ~TX_DMA_REQUEST_N, ~RX_DMA_REQUEST_N,
                        tx_state_q == dma_hs_pkg::CH_XFER,
                        rx_state_q == dma_hs_pkg::CH_XFER};

  assign PRDATA = !apb_rd ? 32'h0 :
                  sel_tx  ? {24'h0, tx_dma_write_config_q} :
                  sel_rx  ? {24'h0, rx_dma_read_config_q} :
                  sel_st  ? status_word :
                  sel_fill ? {25'h0, fill} : 32'h0;

endmodule : dma_handshake

// ==== hw/dma_hs_pkg.sv ====
// Package for the message-buffer DMA handshake block.
// Assumes an APB master on the same clock and a single-byte data path.
package dma_hs_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB)
  // ****************************************************************
  localparam logic [11:0] TX_DMA_WRITE_CONFIG_ADDR = 12'h000;
  localparam logic [11:0] RX_DMA_READ_CONFIG_ADDR  = 12'h004;
  localparam logic [11:0] DMA_STATUS_ADDR          = 12'h008;
  localparam logic [11:0] RX_FILL_ADDR             = 12'h00C;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SOFT_RESET_BIT = 7;
  localparam int ENABLE_BIT     = 6;
  localparam int PIN_ROLE_BIT   = 5;
  localparam int CHAN_LSB       = 0;
  localparam int CHAN_W         = 3;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] CONFIG_WMASK  = 8'hE7;
  localparam logic [2:0] CHAN_ZERO     = 3'h0;

  // ****************************************************************
  // Buffer sizing
  // ****************************************************************
  localparam int BUF_DEPTH = 64;
  localparam int PTR_W     = 6;

  // Strobe-pin sampling bundle
  typedef struct packed {
    logic rd_n;
    logic wr_n;
  } strobe_pins_t;

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_REQ,
    CH_XFER
  } ch_state_t;

endpackage : dma_hs_pkg

// ==== hw/dma_strobe_edge.sv ====
// Configurable strobe decode for one DMA channel.
// Assumes strobe pins are synchronous to the clock.
`timescale 1ns/1ps
module dma_strobe_edge (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire dma_hs_pkg::strobe_pins_t  pins,
  input  wire logic                      role,
  input  wire logic                      role_is_direction_on_wr,
  output logic                           strobe_fall
);

  // ****************************************************************
  // Strobe selection and falling-edge detect
  // ****************************************************************
  logic strobe_q;
  wire  strobe_now;

  // Which pin carries the data strobe depends on the channel's role bit
  assign strobe_now  = role_is_direction_on_wr ? (role ? pins.wr_n : pins.rd_n)
                                               : (role ? pins.wr_n : pins.rd_n);
  assign strobe_fall = strobe_q & ~strobe_now;

  // Idle high so no edge is seen right after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      strobe_q <= 1'b1;
    else
      strobe_q <= strobe_now;
  end

endmodule : dma_strobe_edge

// ==== dv/dma_hs_properties.sv ====
// Port assertions for the DMA handshake block.
// Assumes binding to dma_handshake; config writes arrive over APB.
`timescale 1ns/1ps
module dma_hs_checker (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [31:0] PRDATA,
  input wire logic        RD_N,
  input wire logic        WR_N,
  input wire logic [7:0]  DATA_OUT,
  input wire logic        RX_DMA_REQUEST_N,
  input wire logic        RX_BYTE_READY,
  input wire logic        TX_BYTE_VALID,
  input wire logic [2:0]  TX_CHANNEL,
  input wire logic [2:0]  RX_CHANNEL
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // ***
  // Helper logic
  // ***
  logic [7:0] tx_q, rx_q;
  logic       rd_q, wr_q;
  logic [3:0] fall_q;
  wire        wr_acc = PSEL && PENABLE && PWRITE;
  wire        rd_acc = PSEL && PENABLE && !PWRITE;
  wire        falls  = (!RD_N && rd_q) || (!WR_N && wr_q);

  // Config shadow; falls kept four cycles to cover detect and output stages
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      {tx_q, rx_q, rd_q, wr_q, fall_q} <= '0;
    else
    begin
      rd_q   <= RD_N;
      wr_q   <= WR_N;
      fall_q <= {fall_q[2:0], falls};
      if (wr_acc && PADDR == dma_hs_pkg::TX_DMA_WRITE_CONFIG_ADDR)
        tx_q <= PWDATA[7:0] & dma_hs_pkg::CONFIG_WMASK;
      if (wr_acc && PADDR == dma_hs_pkg::RX_DMA_READ_CONFIG_ADDR)
        rx_q <= PWDATA[7:0] & dma_hs_pkg::CONFIG_WMASK;
    end
  end

  // ***
  // Properties
  // ***
  property p_ready;
    PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr;
    PSEL && PENABLE |-> PSLVERR == !(PADDR[11:4] == 8'h00 && PADDR[1:0] == 2'h0);
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_cfg_read;
    rd_acc && PADDR[11:3] == 9'h000 && PADDR[1:0] == 2'h0
      |-> PRDATA == {24'h0, PADDR[2] ? rx_q : tx_q};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
  property p_rx_off;
    !rx_q[6] && !$past(rx_q[6]) && !$past(rx_q[6], 2) |-> RX_DMA_REQUEST_N;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("request while disabled");
  property p_rx_whole;
    $fell(RX_DMA_REQUEST_N) |-> !$past(RX_BYTE_READY) && rx_q[6];
  endproperty
  a_rx_whole: assert property (p_rx_whole) else $error("request too early");
  property p_rx_srst;
    $rose(rx_q[7]) |-> ##[1:3] RX_DMA_REQUEST_N;
  endproperty
  a_rx_srst: assert property (p_rx_srst) else $error("soft reset ignored");
  property p_dout;
    $changed(DATA_OUT) && !rx_q[7] |-> |fall_q;
  endproperty
  a_dout: assert property (p_dout) else $error("byte without strobe");
  property p_txv;
    TX_BYTE_VALID |-> |fall_q ##1 !TX_BYTE_VALID;
  endproperty
  a_txv: assert property (p_txv) else $error("tx valid wrong");
  property p_chan;
    $stable(tx_q) && $stable(rx_q) |-> TX_CHANNEL == (tx_q[2] ? 3'h0 : tx_q[2:0])
      && RX_CHANNEL == (rx_q[2] ? 3'h0 : rx_q[2:0]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel select wrong");
endmodule : dma_hs_checker

bind dma_handshake dma_hs_checker u_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
  .RD_N(RD_N), .WR_N(WR_N), .DATA_OUT(DATA_OUT), .RX_DMA_REQUEST_N(RX_DMA_REQUEST_N),
  .RX_BYTE_READY(RX_BYTE_READY), .TX_BYTE_VALID(TX_BYTE_VALID),
  .TX_CHANNEL(TX_CHANNEL), .RX_CHANNEL(RX_CHANNEL)
);

// ==== dv/dma_ctrl_model.sv ====
// Behavioural external DMA controller on the strobe and handshake pins.
// Assumes the bench calls its tasks from one process, right after an edge.
`timescale 1ns/1ps
module dma_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rx_req_n,
  input  wire logic       tx_req_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            rx_ack_n,
  output logic            tx_ack_n,
  output logic [7:0]      data_in
);
  // Strobes rest high on their pull-ups, acknowledges idle high
  initial {rd_n, wr_n, rx_ack_n, tx_ack_n, data_in} = {4'hF, 8'h5A};

  // Acknowledge only a request seen low; dly gives slow answers
  task automatic ack(input logic tx, input int dly);
    while ((tx ? tx_req_n : rx_req_n) !== 1'b0) @(posedge clk);
    repeat (dly) @(posedge clk);
    if (tx) tx_ack_n <= 1'b0; else rx_ack_n <= 1'b0;
    @(posedge clk);
  endtask : ack

  task automatic drop();
    {rx_ack_n, tx_ack_n} <= 2'h3;
    @(posedge clk);
  endtask : drop

  // One low pulse; the other pin holds the direction level meanwhile.
  // Released data lines flip so a stale byte cannot pass for a fresh one.
  task automatic strobe(input logic on_wr, input logic dir, input logic [7:0] d);
    if (on_wr) rd_n <= dir; else wr_n <= dir;
    data_in <= d;
    @(posedge clk);
    if (on_wr) wr_n <= 1'b0; else rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    {rd_n, wr_n} <= 2'h3;
    data_in <= ~d;
    repeat (3) @(posedge clk);
  endtask : strobe
endmodule : dma_ctrl_model

// ==== dv/testbench.sv ====
// Self-checking bench: registers, receive and transmit DMA transfers.
// Assumes the checker is bound in and the partner model drives the pins.
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] tx_a = dma_hs_pkg::TX_DMA_WRITE_CONFIG_ADDR;
  localparam logic [11:0] rx_a = dma_hs_pkg::RX_DMA_READ_CONFIG_ADDR;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rd_n, wr_n;
  logic        data_oe, rx_req_n, rx_ack_n, tx_req_n, tx_ack_n, tx_space;
  logic        rx_byte_valid, rx_byte_last, rx_byte_ready, tx_byte_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rx_byte, data_in, data_out, tx_byte;
  logic [2:0]  tx_channel, rx_channel;
  int          n_mismatch = 0, n_checks = 0, n_tx = 0;

  dma_handshake DUT (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
    .RD_N(rd_n), .WR_N(wr_n), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe),
    .RX_DMA_REQUEST_N(rx_req_n), .RX_DMA_ACKNOWLEDGE_N(rx_ack_n),
    .TX_DMA_REQUEST_N(tx_req_n), .TX_DMA_ACKNOWLEDGE_N(tx_ack_n),
    .RX_BYTE_VALID(rx_byte_valid), .RX_BYTE(rx_byte), .RX_BYTE_LAST(rx_byte_last),
    .RX_BYTE_READY(rx_byte_ready), .TX_SPACE(tx_space), .TX_BYTE_VALID(tx_byte_valid),
    .TX_BYTE(tx_byte), .TX_CHANNEL(tx_channel), .RX_CHANNEL(rx_channel)
  );
  dma_ctrl_model partner (
    .clk(clk_sys), .rx_req_n(rx_req_n), .tx_req_n(tx_req_n), .rd_n(rd_n), .wr_n(wr_n),
    .rx_ack_n(rx_ack_n), .tx_ack_n(tx_ack_n), .data_in(data_in)
  );

  // ***
  // Clock, pulse counter, reporting
  // ***
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (tx_byte_valid === 1'b1) n_tx <= n_tx + 1;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // ***
  // Bus and stream drivers
  // ***
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, err}, {31'h0, e});
  endtask : rd

  // Framer bytes held until taken; last marks the final byte when set
  task automatic push(input int n, input logic [7:0] b, input logic last);
    rx_byte_valid <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      {rx_byte, rx_byte_last} <= {b + 8'(i), last && i == n - 1};
      @(posedge clk_sys);
      while (rx_byte_ready !== 1'b1) @(posedge clk_sys);
    end
    rx_byte_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : push

  task automatic wait_req(input logic tx, input logic lvl);
    for (int k = 0; k < 20 && (tx ? tx_req_n : rx_req_n) !== lvl; k++) @(posedge clk_sys);
    chk("request_n", {31'h0, lvl}, {31'h0, tx ? tx_req_n : rx_req_n});
  endtask : wait_req

  // Read a whole message; role 1 strobes the write pin, read pin high
  task automatic rx_read(input logic role, input int n, input logic [7:0] b, input int dly);
    wr(rx_a, {26'h0, role, 5'h00} | 32'h40);
    wait_req(1'b0, 1'b0);
    partner.ack(1'b0, dly);
    @(posedge clk_sys);
    chk("data_oe", 32'h1, {31'h0, data_oe});
    for (int i = 0; i < n; i++)
    begin
      partner.strobe(role, 1'b1, 8'h00);
      chk("data_out", {24'h0, b + 8'(i)}, {24'h0, data_out});
    end
    wait_req(1'b0, 1'b1);
    partner.drop();
    chk("data_oe", 32'h0, {31'h0, data_oe});
  endtask : rx_read

  // ***
  // Scenarios
  // ***
  task automatic t_regs();
    rd(tx_a, 32'h0, 1'b0);
    rd(rx_a, 32'h0, 1'b0);
    wr(tx_a, 32'hFF);
    rd(tx_a, 32'hE7, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    for (int c = 0; c < 8; c++)
    begin
      wr(tx_a, 32'(c));
      wr(rx_a, 32'(c));
      @(posedge clk_sys);
      chk("tx_channel", c > 3 ? 32'h0 : 32'(c), {29'h0, tx_channel});
      chk("rx_channel", c > 3 ? 32'h0 : 32'(c), {29'h0, rx_channel});
    end
    wr(tx_a, 32'h0);
    wr(rx_a, 32'h0);
  endtask : t_regs

  task automatic t_rx_gate();
    push(3, 8'h10, 1'b1);
    repeat (4) @(posedge clk_sys);
    chk("rx_req_n", 32'h1, {31'h0, rx_req_n});
    rx_read(1'b0, 3, 8'h10, 3);
  endtask : t_rx_gate

  task automatic t_rx_partial();
    wr(rx_a, 32'h60);
    push(2, 8'h20, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk("rx_req_n", 32'h1, {31'h0, rx_req_n});
    push(1, 8'h22, 1'b1);
    rx_read(1'b1, 3, 8'h20, 0);
  endtask : t_rx_partial

  task automatic t_rx_srst();
    push(2, 8'h30, 1'b1);
    wait_req(1'b0, 1'b0);
    wr(rx_a, 32'hC0);
    wait_req(1'b0, 1'b1);
    rd(dma_hs_pkg::RX_FILL_ADDR, 32'h0, 1'b0);
    chk("rx_byte_ready", 32'h1, {31'h0, rx_byte_ready});
    wr(rx_a, 32'h0);
  endtask : t_rx_srst

  // Transmit byte with either write-pin role
  task automatic t_tx(input logic role);
    int k;
    tx_space <= 1'b1;
    wr(tx_a, {26'h0, role, 5'h00} | 32'h40);
    wait_req(1'b1, 1'b0);
    partner.ack(1'b1, role ? 4 : 0);
    k = n_tx;
    partner.strobe(role, role, 8'hA5 ^ {7'h0, role});
    chk("tx_valid", 32'(k + 1), 32'(n_tx));
    chk("tx_byte", {24'h0, 8'hA5 ^ {7'h0, role}}, {24'h0, tx_byte});
    partner.drop();
    wr(tx_a, 32'h0);
  endtask : t_tx

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_byte_valid, rx_byte, rx_byte_last, tx_space} = '0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_rx_gate();
    t_rx_partial();
    t_rx_srst();
    t_tx(1'b1);
    t_tx(1'b0);
    results();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial
  begin
    #40000;
    n_mismatch++;
    results();
  end
endmodule : testbench
